// *** rtl/cgc_ctrl_mem.sv ***
// Purpose: Per-generator control and divide storage
// Assumes: One write port, one registered read port
// Notes:   Power and user reset restore differently
`timescale 1ns/1ps
`default_nettype none
module cgc_ctrl_mem (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        user_reset,
    input  wire logic [cgc_pkg::NUM_GEN-1:0] protect,
    input  wire logic                        ctrl_we,
    input  wire logic                        div_we,
    input  wire logic [2:0]                  wr_id,
    input  wire cgc_pkg::cgc_ctrl_t          ctrl_wdata,
    input  wire logic [15:0]                 div_wdata,
    input  wire logic [2:0]                  rd_id,
    output cgc_pkg::cgc_ctrl_t               ctrl_rdata,
    output logic [15:0]                      div_rdata,
    output cgc_pkg::cgc_ctrl_t [cgc_pkg::NUM_GEN-1:0] ctrl_all,
    output logic [cgc_pkg::NUM_GEN-1:0][15:0] div_all
);
    typedef struct packed {
        cgc_pkg::cgc_ctrl_t [cgc_pkg::NUM_GEN-1:0] ctrl;
        logic [cgc_pkg::NUM_GEN-1:0][15:0]         div;
        cgc_pkg::cgc_ctrl_t                        rc;
        logic [15:0]                               rd;
    } cgc_mem_state_t;
    cgc_mem_state_t st_r, st_nxt;
    function automatic cgc_pkg::cgc_ctrl_t rst_val(input int i);
        logic [31:0] v;
        v = (i == 0) ? cgc_pkg::GEN0_RESET : (i == 2) ? cgc_pkg::GEN2_RESET : 32'h0; // R9
        rst_val = v[21:8] & 14'h3f1f;
    endfunction
    function automatic logic [15:0] div_mask(input int i);
        div_mask = (i == 1) ? 16'hffff : (i == 2) ? 16'h001f : 16'h00ff; // R11 R12
    endfunction
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < cgc_pkg::NUM_GEN; i++) begin
            if (ctrl_we && wr_id == i[2:0])
                st_nxt.ctrl[i] = ctrl_wdata;
            if (div_we && wr_id == i[2:0])
                st_nxt.div[i] = div_wdata & div_mask(i); // R10
            if (user_reset && (i == 0 || !protect[i])) begin
                st_nxt.ctrl[i] = rst_val(i); // R8
                st_nxt.div[i] = 16'h0; // R14
            end
        end
        st_nxt.rc = st_nxt.ctrl[rd_id];
        st_nxt.rd = st_nxt.div[rd_id];
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < cgc_pkg::NUM_GEN; i++) begin
                st_r.ctrl[i] <= rst_val(i); // R7
                st_r.div[i] <= 16'h0; // R14
            end
            st_r.rc <= '0;
            st_r.rd <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign ctrl_rdata = st_r.rc;
    assign div_rdata = st_r.rd;
    assign ctrl_all = st_r.ctrl;
    assign div_all = st_r.div;
    a_div2_width: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r.div[2][15:5] == 11'h0) else $error("gen2 divider too wide"); // R11
    a_gen0_user_reset: assert property (@(posedge mclk) disable iff (!reset_n)
        user_reset |=> st_r.div[0] == 16'h0 && st_r.ctrl[0].generator_on) else $error("gen0 not restored"); // R8
endmodule // cgc_ctrl_mem
`default_nettype wire

// *** rtl/cgc_divider.sv ***
// Purpose: One clock generator: divides a selected source
// Assumes: Source is a synchronous level sampled on mclk
// Notes:   Duty balance uses both source edges
`timescale 1ns/1ps
`default_nettype none
module cgc_divider #(
    parameter int DIV_W = 8
) (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        src_level,
    input  wire logic                        run,
    input  wire logic                        pow2,
    input  wire logic                        balance,
    input  wire logic [cgc_pkg::DIV_MAX_W-1:0] factor,
    output logic                             clk_out
);
    if (DIV_W < 1 || DIV_W > cgc_pkg::DIV_MAX_W) begin : g_bad_width
        $error("bad DIV_W");
    end
    typedef struct packed {
        logic        src_d;
        logic [17:0] cnt;
        logic        out;
    } cgc_div_state_t;
    cgc_div_state_t st_r, st_nxt;
    logic [17:0] half_edges;
    logic [17:0] n;
    logic        edge_any;
    logic [18:0] cnt_step;
    always_comb begin
        n = {2'h0, factor};
        if (pow2) // R15
            n = 18'h1 << (factor[4:0] + 5'h1);
        if (n < 18'h2)
            n = 18'h1; // R18
        // Count source edges; a full period is 2*n edges
        half_edges = n;
        edge_any = st_r.src_d != src_level;
        // One bit wider so the largest factor does not wrap the compare
        cnt_step = {1'b0, st_r.cnt} + (balance ? 19'h1 : 19'h2);
        st_nxt = st_r;
        st_nxt.src_d = src_level;
        if (!run) begin // R4
            st_nxt.cnt = 18'h0;
            st_nxt.out = 1'b0;
        end else if (n == 18'h1) begin
            st_nxt.out = src_level; // R18
        end else if (edge_any && (balance || src_level)) begin // R3
            if (cnt_step >= {half_edges, 1'b0}) begin
                st_nxt.cnt = 18'h0;
                st_nxt.out = 1'b1;
            end else begin
                st_nxt.cnt = cnt_step[17:0];
                if (balance ? (cnt_step >= {1'b0, half_edges}) : (cnt_step >= {1'b0, n[17:1], 1'b0}))
                    st_nxt.out = 1'b0;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign clk_out = st_r.out;
    a_stop_holds_low: assert property (@(posedge mclk) disable iff (!reset_n)
        !run |=> !st_r.out) else $error("output not low when stopped"); // R4
    a_bypass_follows: assert property (@(posedge mclk) disable iff (!reset_n)
        (run && !pow2 && factor < 16'h2) |=> st_r.out == $past(src_level)) else $error("bypass wrong"); // R18
    c_div_toggle: cover property (@(posedge mclk) run && $rose(st_r.out));
endmodule // cgc_divider
`default_nettype wire

// *** rtl/cgc_pkg.sv ***
// Purpose: Shared constants and types for the clock generator control block
// Assumes: APB slave, 32-bit data, mclk at 200 MHz
// Notes:   Offsets are byte addresses
package cgc_pkg;
    localparam int          NUM_GEN      = 8;
    localparam int          DIV_MAX_W    = 16;
    localparam logic [11:0] OFF_STATUS   = 12'h000;
    localparam logic [11:0] OFF_CTRL     = 12'h004;
    localparam logic [11:0] OFF_DIV      = 12'h008;
    localparam logic [11:0] OFF_PROTECT  = 12'h00c;
    localparam int          ID_LO        = 0;
    localparam int          ID_HI        = 3;
    localparam int          SRC_LO       = 8;
    localparam int          SRC_HI       = 12;
    localparam int          GENON_BIT    = 16;
    localparam int          DUTY_BIT     = 17;
    localparam int          IDLE_BIT     = 18;
    localparam int          OE_BIT       = 19;
    localparam int          P2_BIT       = 20;
    localparam int          STDBY_BIT    = 21;
    localparam int          DIV_LO       = 8;
    localparam int          DIV_HI       = 23;
    localparam int          SYNC_BIT     = 7;
    localparam logic [31:0] GEN0_RESET   = 32'h00010600;
    localparam logic [31:0] GEN2_RESET   = 32'h00010302;
    localparam logic [31:0] CTRL_MASK    = 32'h003f1f0f;
    localparam logic [4:0]  SRC_PAD      = 5'h01;
    localparam int          SYNC_CYCLES  = 3;
    typedef struct packed {
        logic       keep_in_standby;
        logic       power_of_two_select;
        logic       output_enable;
        logic       pin_idle_level;
        logic       duty_balance;
        logic       generator_on;
        logic [2:0] spare;
        logic [4:0] source_select;
    } cgc_ctrl_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cgc_apb_req_t;
endpackage

// *** rtl/cgc_top.sv ***
// Purpose: Clock generator bank control with APB registers
// Assumes: Sources and pad levels synchronous to mclk
// Notes:   Divider writes raise a sync busy flag
// Operation
// R1: Output enable drives generator clock to its pin unless the pin is its source.
// R2: Generator off or output disabled holds the pin at the idle level.
// R3: Duty balance gives 50/50 duty for odd divide factors.
// R4: Generator runs only while its enable bit is one.
// R5: Five-bit source field picks one of eight sources; higher codes reserved.
// R6: Control index field picks generator 0 to 7; software avoids higher values.
// R7: Power reset restores every generator's control value.
// R8: User reset restores generators 1-7 only if unprotected; generator 0 always.
// R9: Reset control: gen 0 on with 8 MHz, gen 2 on with low-power 32k.
// R10: Divide register bits 23:8 hold factor; bits above implemented width ignored.
// R11: Divider widths: 8, 16, 5, then 8 for the rest.
// R12: Maximum factors 512, 131072, 64, and 512.
// R13: Divide index field picks generators 0 to 7; reserved values unused.
// R14: Power reset clears all factors; user reset clears unprotected ones except 0 always.
// R15: Power-of-two select divides by two to the factor plus one.
// R16: Output enable with standby keep keeps the pin running in standby.
// R17: Divider writes synchronise before use; busy flag shows while pending.
// R18: Factor zero or one passes the source undivided.
`timescale 1ns/1ps
`default_nettype none
module cgc_top (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        user_reset,
    input  wire logic                        standby,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        external_crystal,
    input  wire logic                        ultra_low_power_32k,
    input  wire logic                        internal_32k,
    input  wire logic                        external_32k_crystal,
    input  wire logic                        internal_8mhz_rc,
    input  wire logic                        loop_48mhz,
    input  wire logic [cgc_pkg::NUM_GEN-1:0] generator_pin_in,
    output logic [cgc_pkg::NUM_GEN-1:0]      generator_pin_out,
    output logic [cgc_pkg::NUM_GEN-1:0]      generator_pin_oe,
    output logic [cgc_pkg::NUM_GEN-1:0]      gen_clk
);
    typedef struct packed {
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic                        rd_phase;
        logic [3:0]                  ctrl_id;
        logic [3:0]                  div_id;
        logic [cgc_pkg::NUM_GEN-1:0] protect;
        logic [1:0]                  sync_cnt;
        logic [15:0]                 div_pend;
        logic [2:0]                  div_pend_id;
        logic [cgc_pkg::NUM_GEN-1:0] pin_out;
        logic [cgc_pkg::NUM_GEN-1:0] pin_oe;
        logic [cgc_pkg::NUM_GEN-1:0] clk;
    } cgc_state_t;
    cgc_state_t st_r, st_nxt;
    cgc_pkg::cgc_apb_req_t req;
    cgc_pkg::cgc_ctrl_t ctrl_rdata;
    cgc_pkg::cgc_ctrl_t ctrl_wdata;
    cgc_pkg::cgc_ctrl_t [cgc_pkg::NUM_GEN-1:0] ctrl_all;
    logic [cgc_pkg::NUM_GEN-1:0][15:0] div_all;
    logic [15:0] div_rdata;
    logic [cgc_pkg::NUM_GEN-1:0] div_clk;
    logic [cgc_pkg::NUM_GEN-1:0] src_lvl;
    logic ctrl_we;
    logic div_we;
    logic [2:0] wr_id;
    logic [2:0] rd_id;
    logic setup;
    logic access;
    logic mapped;
    logic busy;
    logic [4:0] sync_len;
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign setup = req.psel && !req.penable;
    assign access = req.psel && req.penable && st_r.pready;
    assign busy = st_r.sync_cnt != 2'h0;
    assign sync_len = 5'(cgc_pkg::SYNC_CYCLES);
    assign mapped = req.paddr == cgc_pkg::OFF_STATUS || req.paddr == cgc_pkg::OFF_CTRL
                 || req.paddr == cgc_pkg::OFF_DIV || req.paddr == cgc_pkg::OFF_PROTECT;
    // Control write lands in the access cycle once ready is high; index field chooses the slot
    assign ctrl_we = access && req.pwrite && req.paddr == cgc_pkg::OFF_CTRL && !req.pwdata[3]; // R6
    assign ctrl_wdata = req.pwdata[21:8] & 14'h3f1f;
    assign div_we = st_r.sync_cnt == 2'h1; // R17
    assign wr_id = ctrl_we ? req.pwdata[2:0] : st_r.div_pend_id;
    assign rd_id = (setup && req.paddr == cgc_pkg::OFF_DIV) ? st_r.div_id[2:0] : st_r.ctrl_id[2:0];
    cgc_ctrl_mem u_mem (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .user_reset (user_reset),
        .protect    (st_r.protect),
        .ctrl_we    (ctrl_we),
        .div_we     (div_we),
        .wr_id      (wr_id),
        .ctrl_wdata (ctrl_wdata),
        .div_wdata  (st_r.div_pend),
        .rd_id      (rd_id),
        .ctrl_rdata (ctrl_rdata),
        .div_rdata  (div_rdata),
        .ctrl_all   (ctrl_all),
        .div_all    (div_all)
    );
    genvar g;
    generate
        for (g = 0; g < cgc_pkg::NUM_GEN; g++) begin : gen_div
            localparam int W = (g == 1) ? 16 : (g == 2) ? 5 : 8;
            always_comb begin
                case (ctrl_all[g].source_select) // R5
                    5'h00:   src_lvl[g] = external_crystal;
                    5'h01:   src_lvl[g] = generator_pin_in[g];
                    5'h02:   src_lvl[g] = (g == 1) ? 1'b0 : st_r.clk[1];
                    5'h03:   src_lvl[g] = ultra_low_power_32k;
                    5'h04:   src_lvl[g] = internal_32k;
                    5'h05:   src_lvl[g] = external_32k_crystal;
                    5'h06:   src_lvl[g] = internal_8mhz_rc;
                    5'h07:   src_lvl[g] = loop_48mhz;
                    default: src_lvl[g] = 1'b0;
                endcase
            end
            cgc_divider #(.DIV_W(W)) u_div (
                .mclk    (mclk),
                .reset_n (reset_n),
                .src_level (src_lvl[g]),
                .run     (ctrl_all[g].generator_on && !(standby && !(ctrl_all[g].keep_in_standby && ctrl_all[g].output_enable))), // R4 R16
                .pow2    (ctrl_all[g].power_of_two_select),
                .balance (ctrl_all[g].duty_balance),
                .factor  (div_all[g]),
                .clk_out (div_clk[g])
            );
        end
    endgenerate
    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        // Reads take one wait state: the stored word is registered first
        if (setup) begin
            st_nxt.pready = req.pwrite;
            st_nxt.pslverr = req.pwrite && !mapped;
        end
        if (access && !req.pwrite) begin
            st_nxt.prdata = 32'h0;
        end
        if (setup && !req.pwrite) begin
            st_nxt.rd_phase = 1'b1;
        end
        if (st_r.rd_phase) begin
            st_nxt.rd_phase = 1'b0;
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !mapped;
            case (req.paddr)
                cgc_pkg::OFF_STATUS:  st_nxt.prdata = {24'h0, busy, 7'h0}; // R17
                cgc_pkg::OFF_CTRL:    st_nxt.prdata = {10'h0, ctrl_rdata, 4'h0, st_r.ctrl_id};
                cgc_pkg::OFF_DIV:     st_nxt.prdata = {8'h0, div_rdata, 4'h0, st_r.div_id};
                cgc_pkg::OFF_PROTECT: st_nxt.prdata = {24'h0, st_r.protect};
                default:              st_nxt.prdata = 32'h0;
            endcase
        end
        if (access && req.pwrite) begin
            case (req.paddr)
                cgc_pkg::OFF_CTRL:    st_nxt.ctrl_id = req.pwdata[3:0]; // R6
                cgc_pkg::OFF_DIV: begin
                    st_nxt.div_id = req.pwdata[3:0]; // R13
                    if (!req.pwdata[3] && !busy) begin
                        st_nxt.div_pend = req.pwdata[23:8]; // R10
                        st_nxt.div_pend_id = req.pwdata[2:0];
                        st_nxt.sync_cnt = sync_len[1:0]; // R17
                    end
                end
                cgc_pkg::OFF_PROTECT: st_nxt.protect = req.pwdata[7:0];
                default: ;
            endcase
        end
        if (busy)
            st_nxt.sync_cnt = st_r.sync_cnt - 2'h1;
        for (int i = 0; i < cgc_pkg::NUM_GEN; i++) begin
            st_nxt.clk[i] = div_clk[i];
            st_nxt.pin_oe[i] = ctrl_all[i].source_select != cgc_pkg::SRC_PAD; // R1
            if (ctrl_all[i].output_enable && ctrl_all[i].generator_on
                && !(standby && !ctrl_all[i].keep_in_standby))
                st_nxt.pin_out[i] = div_clk[i]; // R1 R16
            else
                st_nxt.pin_out[i] = ctrl_all[i].pin_idle_level; // R2
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign generator_pin_out = st_r.pin_out;
    assign generator_pin_oe = st_r.pin_oe;
    assign gen_clk = st_r.clk;
    a_idle_level: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctrl_all[3].output_enable |=> generator_pin_out[3] == $past(ctrl_all[3].pin_idle_level)) else $error("idle level wrong"); // R2
    a_pad_not_driven: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_all[4].source_select == 5'h01 |=> !generator_pin_oe[4]) else $error("pad source driven"); // R1
    a_sync_busy: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(busy) |-> busy [*3] ##1 !busy) else $error("sync length wrong"); // R17
    a_div_index_read: assert property (@(posedge mclk) disable iff (!reset_n)
        access && req.pwrite && req.paddr == cgc_pkg::OFF_DIV |=> st_r.div_id == $past(req.pwdata[3:0])) else $error("index lost"); // R13
    a_ready_one: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && req.pwrite |=> pready) else $error("no ready"); // R6
    a_read_wait: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && !req.pwrite |=> !pready ##1 pready) else $error("read ready timing wrong"); // R6
    c_ctrl_write: cover property (@(posedge mclk) ctrl_we);
    c_div_sync: cover property (@(posedge mclk) div_we);
    c_pin_drive: cover property (@(posedge mclk) generator_pin_oe[0] && $rose(generator_pin_out[0]));
endmodule // cgc_top
`default_nettype wire

// *** verification/cgc_src_model.sv ***
// Purpose: Oscillator sources and generator pads around the clock block
// Assumes: Sources are synchronous levels, slower than half of mclk
// Notes:   Pad wire resolves to the block while its enable is high
`timescale 1ns/1ps
`default_nettype none
module cgc_src_model (
    input  wire logic       mclk,
    output logic [5:0]      src,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    output logic [7:0]      pin_in
);
    int c = 0;
    always @(posedge mclk) c <= c + 1;
    // Free running sources with distinct half periods
    assign src[0] = ((c / 3) % 2) == 1;
    assign src[1] = ((c / 8) % 2) == 1;
    assign src[2] = ((c / 7) % 2) == 1;
    assign src[3] = ((c / 9) % 2) == 1;
    assign src[4] = ((c / 2) % 2) == 1;
    assign src[5] = ((c / 4) % 2) == 1;
    // Pad level: block drives when enabled, else the outside clock
    for (genvar i = 0; i < 8; i++) begin : g_pad
        assign pin_in[i] = pin_oe[i] ? pin_out[i] : (((c / 6) % 2) == 1);
    end
endmodule // cgc_src_model
`default_nettype wire

// *** verification/cgc_top_test.sv ***
// Purpose: Self-checking bench for the clock generator block
// Assumes: APB slave answers after setup; divide writes poll busy
// Notes:   Sources come from the partner model
`timescale 1ns/1ps
`default_nettype none
module cgc_top_test;
    logic mclk = 0, reset_n = 0, user_reset = 0, standby = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [5:0]  src;
    logic [7:0]  pin_in, pin_out, pin_oe, gen_clk;
    logic        er;
    int          error_cnt = 0, total_checks = 0, per, hi, lo, n;
    int dv[5] = '{1, 0, 3, 3, 2};
    int pw[5] = '{0, 0, 0, 0, 1};
    int ep[5] = '{8, 8, 24, 24, 64};
    initial forever #2.5 mclk = ~mclk;
    cgc_top i_dut (.mclk(mclk), .reset_n(reset_n), .user_reset(user_reset), .standby(standby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_crystal(src[0]),
        .ultra_low_power_32k(src[1]), .internal_32k(src[2]), .external_32k_crystal(src[3]),
        .internal_8mhz_rc(src[4]), .loop_48mhz(src[5]), .generator_pin_in(pin_in),
        .generator_pin_out(pin_out), .generator_pin_oe(pin_oe), .gen_clk(gen_clk));
    cgc_src_model i_src (.mclk(mclk), .src(src), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do begin
            @(posedge mclk);
            k++;
            if (k > 20) begin chk("pready wait", 0, 1); close_out(); end
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic div_wr(input int id, input logic [15:0] f);
        int k;
        apb(1, cgc_pkg::OFF_DIV, {8'h00, f, 4'h0, 4'(id)});
        k = 0;
        do begin
            apb(0, cgc_pkg::OFF_STATUS, 0);
            k++;
            if (k > 20) begin chk("busy wait", 0, 1); close_out(); end
        end while (rd[cgc_pkg::SYNC_BIT] !== 1'b0);
    endtask
    task automatic wlev(input int i, input logic lv, output int cnt);
        cnt = 0;
        while (gen_clk[i] !== lv) begin
            @(posedge mclk);
            cnt++;
            if (cnt > 600) begin chk("gen_clk wait", 0, 1); close_out(); end
        end
    endtask
    task automatic meas(input int i);
        wlev(i, 0, n); wlev(i, 1, n); wlev(i, 0, hi); wlev(i, 1, lo);
        per = hi + lo;
    endtask
    task automatic tog(input int i, input bit pin, output int cnt);
        logic p;
        cnt = 0;
        // Let a just-written setting reach the registered outputs first
        repeat (4) @(posedge mclk);
        p = pin ? pin_out[i] : gen_clk[i];
        repeat (80) begin
            @(posedge mclk);
            if ((pin ? pin_out[i] : gen_clk[i]) !== p) cnt++;
            p = pin ? pin_out[i] : gen_clk[i];
        end
    endtask
    function automatic logic [31:0] ctl(input int id, s, on, bal, idl, oe, p2, st);
        return 32'(id) | 32'(s) << cgc_pkg::SRC_LO | 32'(on) << cgc_pkg::GENON_BIT
            | 32'(bal) << cgc_pkg::DUTY_BIT | 32'(idl) << cgc_pkg::IDLE_BIT
            | 32'(oe) << cgc_pkg::OE_BIT | 32'(p2) << cgc_pkg::P2_BIT | 32'(st) << cgc_pkg::STDBY_BIT;
    endfunction
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1;
        apb(0, cgc_pkg::OFF_CTRL, 0);
        chk("ctrl0 reset", rd, cgc_pkg::GEN0_RESET);
        chk("pin_oe reset", pin_oe, 8'hff);
        chk("pin_out reset", pin_out, 8'h00);
        tog(0, 0, n); chk("gen0 runs", n > 0, 1);
        tog(2, 0, n); chk("gen2 runs", n > 0, 1);
        tog(1, 0, n); chk("gen1 off", n, 0);
        for (int s = 0; s < 8; s++) begin
            apb(1, cgc_pkg::OFF_CTRL, ctl(4, s, 1, 0, 1, 1, 0, 0));
            tog(4, 0, n);
            chk("source sel", n > 0, s != 2);
            chk("pad oe", pin_oe[4], s != 1);
        end
        apb(1, cgc_pkg::OFF_CTRL, ctl(4, 7, 1, 0, 1, 1, 0, 0));
        tog(4, 1, n); chk("pin drives clk", n > 0, 1);
        apb(1, cgc_pkg::OFF_CTRL, ctl(4, 7, 0, 0, 1, 1, 0, 0));
        tog(4, 1, n); chk("pin off idle1", {n[7:0], pin_out[4]}, 9'h001);
        apb(1, cgc_pkg::OFF_CTRL, ctl(4, 7, 1, 0, 0, 0, 0, 0));
        tog(4, 1, n); chk("pin oe0 idle0", {n[7:0], pin_out[4]}, 9'h000);
        apb(1, cgc_pkg::OFF_CTRL, 32'hffc0e0f3);
        apb(0, cgc_pkg::OFF_CTRL, 0);
        chk("ctrl readback", rd, 32'hffc0e0f3 & cgc_pkg::CTRL_MASK);
        apb(1, cgc_pkg::OFF_DIV, {8'h00, 16'h0001, 8'h06});
        apb(0, cgc_pkg::OFF_STATUS, 0);
        chk("sync busy", rd[cgc_pkg::SYNC_BIT], 1);
        for (int i = 0; i < 8; i++) begin
            div_wr(i, 16'hffff);
            apb(0, cgc_pkg::OFF_DIV, 0);
            chk("div width", rd, {8'h00, (i == 1) ? 16'hffff : (i == 2) ? 16'h001f : 16'h00ff, 8'(i)});
        end
        for (int k = 0; k < 5; k++) begin
            apb(1, cgc_pkg::OFF_CTRL, ctl(3, 7, 1, k == 2, 0, 1, pw[k], 1));
            div_wr(3, 16'(dv[k]));
            meas(3);
            chk("gen period", per, ep[k]);
            if (k == 2) chk("balanced high", hi, 12);
        end
        apb(1, cgc_pkg::OFF_CTRL, ctl(3, 7, 1, 0, 0, 1, 0, 1));
        div_wr(3, 16'h0003);
        apb(1, cgc_pkg::OFF_CTRL, ctl(5, 7, 1, 0, 1, 1, 0, 0));
        standby <= 1;
        tog(3, 1, n); chk("standby kept", n > 0, 1);
        tog(5, 1, n); chk("standby idle", {n[7:0], pin_out[5]}, 9'h001);
        standby <= 0;
        apb(1, cgc_pkg::OFF_PROTECT, 32'h00000008);
        apb(1, cgc_pkg::OFF_CTRL, ctl(0, 6, 0, 0, 0, 0, 0, 0));
        @(posedge mclk) user_reset <= 1;
        @(posedge mclk) user_reset <= 0;
        repeat (4) @(posedge mclk);
        meas(0); chk("gen0 restored", per, 4);
        meas(3); chk("protected kept", per, 24);
        tog(5, 1, n); chk("gen5 restored", {n[7:0], pin_out[5]}, 9'h000);
        @(posedge mclk) reset_n <= 0;
        repeat (2) @(posedge mclk);
        reset_n <= 1;
        apb(0, cgc_pkg::OFF_CTRL, 0);
        chk("power reset ctrl0", rd, cgc_pkg::GEN0_RESET);
        tog(3, 0, n); chk("gen3 reset off", n, 0);
        apb(0, 12'h010, 0);
        chk("unmapped err", er, 1);
        close_out();
    end
endmodule // cgc_top_test
`default_nettype wire
